// ==== src/sdswl_pkg.sv ====
// Purpose: Shared constants and types of the switch detect serial wake logic
// Assumes: 24-bit serial words, 8 dual-polarity and 14 ground-only inputs
// Notes:   Command codes without a fixed value are named here once

package sdswl_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned WORD_W = 24;
  localparam int unsigned DUAL_N = 8;
  localparam int unsigned GND_N = 14;
  localparam int unsigned SW_N = 22;
  localparam int unsigned ANALOG_INPUT_SELECTOR_W = 5;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned SYNC_W = 27;

  // ==========================================================================
  // Command word fields and codes
  localparam int unsigned OPC_MSB = 23;
  localparam int unsigned OPC_LSB = 16;
  localparam logic [7:0] CMD_SETTINGS = 8'h01;
  localparam logic [7:0] CMD_WAKE_DUAL = 8'h02;
  localparam logic [7:0] CMD_WAKE_GND = 8'h03;
  localparam logic [7:0] CMD_ANALOG = 8'h30;
  localparam logic [7:0] CMD_SLEEP = 8'h15;
  localparam logic [7:0] CMD_RESET = 8'h7f;

  // ==========================================================================
  // Frame lengths accepted as complete, bit count ceiling and first count
  localparam logic [CNT_W-1:0] BITS_ONE = 6'h18;
  localparam logic [CNT_W-1:0] BITS_TWO = 6'h30;
  localparam logic [CNT_W-1:0] BITS_MAX = 6'h3f;
  localparam logic [CNT_W-1:0] BITS_FIRST = 6'h01;

  // ==========================================================================
  // Status word fields
  localparam int unsigned ST_INT_POS = 23;
  localparam int unsigned ST_THERM_POS = 22;

  // ==========================================================================
  // Synchroniser lanes
  localparam int unsigned SY_CS = 0;
  localparam int unsigned SY_TOG = 1;
  localparam int unsigned SY_INT = 2;
  localparam int unsigned SY_WAKE = 3;
  localparam int unsigned SY_VDD = 4;
  localparam int unsigned SY_SW = 5;

  // ==========================================================================
  // Types
  typedef enum logic [0:0] {
    MODE_NORMAL = 1'b0,
    MODE_SLEEP = 1'b1
  } sdswl_mode_type;

  typedef struct packed {
    logic [ANALOG_INPUT_SELECTOR_W-1:0] analogInputSelector;
    logic [GND_N-1:0] groundInputEnable;
    logic [DUAL_N-1:0] dualInputEnable;
    logic [DUAL_N-1:0] polarityBattery;
  } sdswl_cfg_type;

  localparam sdswl_cfg_type CFG_RESET = '{
    analogInputSelector: 5'h00,
    groundInputEnable: 14'h3fff,
    dualInputEnable: 8'hff,
    polarityBattery: 8'hff
  };

endpackage

// ==== src/sdswl_top.sv ====
// Purpose: Serial slave, switch change interrupt and sleep/wake control
// Assumes: Comparator results arrive as levels, 1 = above the 4.0 V reference
// Notes:   Link logic runs on the host serial clock; the rest on clk
//
// Behaviour
// - Chip select fall enables output driver and snapshots interrupt and switch states.
// - Chip select rise puts the serial output into high impedance.
// - Chip select rise releases interrupt unless a change arrived while selected.
// - Received command takes effect only at chip select rise, then fresh data applies.
// - Falling chip select wakes from sleep with supply; that status may be invalid.
// - Serial input is sampled on each falling serial clock edge.
// - Output shifts on rising edge; host samples on following falling edge.
// - While deselected, clock and input are ignored and output stays tri-stated.
// - A complete command holds exactly 24 or 48 clock bits in one select period.
// - Status reports open switches as 0 and closed switches as 1.
// - First rising edge presents the top status bit, then each lower bit.
// - Command and status move MSB first, together, first in first out.
// - In normal mode an enabled switch change drives the interrupt low.
// - Interrupt flag is captured at select fall and shows only own interrupt.
// - Asleep with wake high and supply, a falling interrupt line wakes.
// - Wake line is held low in normal mode and released in sleep.
// - Asleep, wake fall wakes; with supply only while interrupt line is high.
// - Wake by chip select or interrupt line needs the logic supply.
// - Dual inputs above threshold are closed in battery mode, open in ground mode.
// - Ground-only inputs above threshold are open, below are closed.
// - Settings command 01 loads polarity bits from bits 7 to 0, 1 = battery.
// - Enable bit 0 blocks interrupt and wake for that input; 1 allows both.
// - Reset gives battery polarity, all inputs enabled and analog select 00000.
// - Configuration writes are accepted only in normal mode with logic supply.

`timescale 1ns/1ps
`default_nettype none

module sdswl_top
  import sdswl_pkg::*;
(
  // System clock, reset and enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Serial link
  input wire logic linkSclk,
  input wire logic linkCsN,
  input wire logic linkSi,
  output var logic linkSoOut,
  output var logic linkSoOeN,
  // Shared open-drain interrupt line
  input wire logic intLineIn,
  output var logic intLineOut,
  output var logic intLineOeN,
  // Shared open-drain supply-enable line
  input wire logic wakeLineIn,
  output var logic wakeLineOut,
  output var logic wakeLineOeN,
  // Supply and comparator results
  input wire logic logicSupplyOk,
  input wire logic [sdswl_pkg::DUAL_N-1:0] dualPolarityInputs,
  input wire logic [sdswl_pkg::GND_N-1:0] groundOnlyInputs,
  // Status
  output var sdswl_pkg::sdswl_cfg_type cfgOut,
  output var sdswl_pkg::sdswl_mode_type modeOut
);

  import sdswl_pkg::*;

  // ==========================================================================
  // Declarations
  logic [WORD_W-1:0] rxShiftReg, rxShiftNext;
  logic [CNT_W-1:0] rxCountReg, rxCountNext;
  logic rxTogReg, rxTogNext;
  logic rxFirstReg, txFirstReg;
  logic [WORD_W-2:0] txShiftReg, txShiftNext;
  logic soBitNext;
  logic [WORD_W-1:0] snapReg, snapNext;
  logic [SYNC_W-1:0] syncInput;
  logic [SYNC_W-1:0] sync1Reg, sync2Reg;
  logic csPrevReg, intPrevReg, wakePrevReg;
  logic togSeenReg;
  logic csSync, togSync, intSync, wakeSync, vddSync;
  logic [SW_N-1:0] swAbove;
  logic [SW_N-1:0] closedNow;
  logic [SW_N-1:0] closedPrevReg;
  logic [SW_N-1:0] enMask;
  logic skipReg;
  logic changed;
  logic csFall, csRise, intFall, wakeFall;
  logic newFrame, fullWord, cfgWrite;
  logic [7:0] opcode;
  logic sleepCmd;
  logic wakeEvt;
  sdswl_cfg_type cfgReg, cfgNext;
  sdswl_mode_type modeReg, modeNext;
  logic intAssert;
  logic intOeNNext;
  logic csChangeReg, csChangeNext;

  // ==========================================================================
  // Link receive side, falling serial clock
  assign rxShiftNext = {rxShiftReg[WORD_W-2:0], linkSi};
  assign rxTogNext = rxFirstReg ? ~rxTogReg : rxTogReg;
  assign rxCountNext = rxFirstReg ? BITS_FIRST :
                       (rxCountReg == BITS_MAX) ? BITS_MAX :
                       CNT_W'(rxCountReg + 1'b1);

  always_ff @(negedge linkSclk or posedge linkCsN or posedge sys_rst)
  begin
    if (linkCsN || sys_rst)
    begin
      rxFirstReg <= 1'b1;
    end
    else
    begin
      rxFirstReg <= 1'b0;
    end
  end

  always_ff @(negedge linkSclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rxShiftReg <= '0;
      rxCountReg <= '0;
      rxTogReg <= 1'b0;
    end
    else if (!linkCsN)
    begin
      rxShiftReg <= rxShiftNext;
      rxCountReg <= rxCountNext;
      rxTogReg <= rxTogNext;
    end
  end

  // ==========================================================================
  // Link transmit side, rising serial clock
  assign soBitNext = txFirstReg ? snapReg[WORD_W-1] : txShiftReg[WORD_W-2];
  assign txShiftNext = txFirstReg ? snapReg[WORD_W-2:0] :
                       {txShiftReg[WORD_W-3:0], rxShiftReg[0]};

  always_ff @(posedge linkSclk or posedge linkCsN or posedge sys_rst)
  begin
    if (linkCsN || sys_rst)
    begin
      txFirstReg <= 1'b1;
    end
    else
    begin
      txFirstReg <= 1'b0;
    end
  end

  always_ff @(posedge linkSclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      linkSoOut <= 1'b0;
      txShiftReg <= '0;
    end
    else if (!linkCsN)
    begin
      linkSoOut <= soBitNext;
      txShiftReg <= txShiftNext;
    end
  end

  // ==========================================================================
  // Synchronisers for pins and the frame toggle
  assign syncInput = {groundOnlyInputs, dualPolarityInputs, logicSupplyOk,
                      wakeLineIn, intLineIn, rxTogReg, linkCsN};

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1Reg <= {{(SYNC_W-SY_SW){1'b0}}, 5'h0f};
      sync2Reg <= {{(SYNC_W-SY_SW){1'b0}}, 5'h0f};
    end
    else if (clkEn)
    begin
      sync1Reg <= syncInput;
      sync2Reg <= sync1Reg;
    end
  end

  assign csSync = sync2Reg[SY_CS];
  assign togSync = sync2Reg[SY_TOG];
  assign intSync = sync2Reg[SY_INT];
  assign wakeSync = sync2Reg[SY_WAKE];
  assign vddSync = sync2Reg[SY_VDD];
  assign swAbove = sync2Reg[SYNC_W-1:SY_SW];

  // ==========================================================================
  // Edge detection on synchronised lines
  assign csFall = csPrevReg & ~csSync;
  assign csRise = ~csPrevReg & csSync;
  assign intFall = intPrevReg & ~intSync;
  assign wakeFall = wakePrevReg & ~wakeSync;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      csPrevReg <= 1'b1;
      intPrevReg <= 1'b1;
      wakePrevReg <= 1'b1;
    end
    else if (clkEn)
    begin
      csPrevReg <= csSync;
      intPrevReg <= intSync;
      wakePrevReg <= wakeSync;
    end
  end

  // ==========================================================================
  // Open and closed decode per input
  genvar i;
  generate
    for (i = 0; i < SW_N; i = i + 1)
    begin : g_sw
      if (i < DUAL_N)
      begin : g_dual
        assign closedNow[i] = cfgReg.polarityBattery[i] ? swAbove[i] : ~swAbove[i];
      end
      else
      begin : g_gnd
        assign closedNow[i] = ~swAbove[i];
      end
    end
  endgenerate

  assign enMask = {cfgReg.groundInputEnable, cfgReg.dualInputEnable};
  assign changed = ~skipReg & (|((closedNow ^ closedPrevReg) & enMask));

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      closedPrevReg <= '0;
      skipReg <= 1'b1;
    end
    else if (clkEn)
    begin
      closedPrevReg <= closedNow;
      skipReg <= cfgWrite;
    end
  end

  // ==========================================================================
  // Status snapshot at chip select fall
  assign snapNext = csFall ? {intAssert, 1'b0, closedNow} : snapReg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      snapReg <= '0;
    end
    else if (clkEn)
    begin
      snapReg <= snapNext;
    end
  end

  // ==========================================================================
  // Command decode at chip select rise
  assign newFrame = togSync ^ togSeenReg;
  assign fullWord = (rxCountReg == BITS_ONE) | (rxCountReg == BITS_TWO);
  assign opcode = rxShiftReg[OPC_MSB:OPC_LSB];
  assign cfgWrite = csRise & newFrame & fullWord & (modeReg == MODE_NORMAL) & vddSync;
  assign sleepCmd = cfgWrite & (opcode == CMD_SLEEP);

  always_comb
  begin
    cfgNext = cfgReg;
    if (cfgWrite)
    begin
      unique case (opcode)
        CMD_SETTINGS: cfgNext.polarityBattery = rxShiftReg[DUAL_N-1:0];
        CMD_WAKE_DUAL: cfgNext.dualInputEnable = rxShiftReg[DUAL_N-1:0];
        CMD_WAKE_GND: cfgNext.groundInputEnable = rxShiftReg[GND_N-1:0];
        CMD_ANALOG: cfgNext.analogInputSelector = rxShiftReg[ANALOG_INPUT_SELECTOR_W-1:0];
        CMD_RESET: cfgNext = CFG_RESET;
        default: cfgNext = cfgReg;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfgReg <= CFG_RESET;
      togSeenReg <= 1'b0;
    end
    else if (clkEn)
    begin
      cfgReg <= cfgNext;
      togSeenReg <= csRise ? togSync : togSeenReg;
    end
  end

  // ==========================================================================
  // Interrupt line control
  assign intAssert = ~intLineOeN;
  assign csChangeNext = ((csFall ? 1'b0 : csChangeReg) | (~csSync & changed));
  assign intOeNNext = ((modeReg == MODE_NORMAL) & changed) ? 1'b0 :
                      (csRise & ~csChangeReg) ? 1'b1 :
                      intLineOeN;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      intLineOeN <= 1'b1;
      intLineOut <= 1'b0;
      csChangeReg <= 1'b0;
    end
    else if (clkEn)
    begin
      intLineOeN <= intOeNNext;
      intLineOut <= 1'b0;
      csChangeReg <= csChangeNext;
    end
  end

  // ==========================================================================
  // Normal and sleep mode
  assign wakeEvt = changed |
                   (wakeFall & (~vddSync | intSync)) |
                   (vddSync & intFall & wakeSync) |
                   (vddSync & csFall);

  always_comb
  begin
    modeNext = modeReg;
    unique case (modeReg)
      MODE_NORMAL:
      begin
        if (sleepCmd)
        begin
          modeNext = MODE_SLEEP;
        end
      end
      MODE_SLEEP:
      begin
        if (wakeEvt)
        begin
          modeNext = MODE_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      modeReg <= MODE_NORMAL;
      modeOut <= MODE_NORMAL;
      wakeLineOeN <= 1'b0;
      wakeLineOut <= 1'b0;
    end
    else if (clkEn)
    begin
      modeReg <= modeNext;
      modeOut <= modeNext;
      wakeLineOeN <= (modeNext == MODE_SLEEP);
      wakeLineOut <= 1'b0;
    end
  end

  // ==========================================================================
  // Serial output enable and configuration view
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      linkSoOeN <= 1'b1;
      cfgOut <= CFG_RESET;
    end
    else if (clkEn)
    begin
      linkSoOeN <= csSync;
      cfgOut <= cfgNext;
    end
  end

endmodule

`default_nettype wire

// ==== tb/sdswl_host_model.sv ====
// Purpose: Host serial master facing the device link
// Assumes: Serial clock period 64 ns, idle low
// Notes: rxWord holds the status of the last frame
`timescale 1ns/1ps
`default_nettype none
module sdswl_host_model
(
  // Link toward the device
  output var logic linkSclk,
  output var logic linkCsN,
  output var logic linkSi,
  // Resolved serial output wire
  input wire logic linkSo
);
  // ==========================================================================
  // Frame engine
  logic [23:0] rxWord;
  initial
  begin
    linkSclk = 1'b0;
    linkCsN = 1'b1;
    linkSi = 1'b0;
    rxWord = 24'h000000;
  end
  task automatic xfer(input logic [23:0] cmd, input int nBits);
    linkCsN = 1'b0;
    #64;
    for (int i = 0; i < nBits; i++)
    begin
      linkSclk = 1'b1;
      linkSi = cmd[23-i];
      #32;
      linkSclk = 1'b0;
      rxWord = {rxWord[22:0], linkSo};
      #32;
    end
    linkSi = ~linkSi;
    linkCsN = 1'b1;
    #96;
  endtask
endmodule
`default_nettype wire

// ==== tb/sdswl_properties.sv ====
// Purpose: Port checks of the switch detect serial wake logic
// Assumes: Link pins are sampled on clk
// Notes: Bound into sdswl_top
`timescale 1ns/1ps
`default_nettype none
module sdswl_properties
  import sdswl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Link
  input wire logic linkSclk,
  input wire logic linkCsN,
  input wire logic linkSi,
  input wire logic linkSoOut,
  input wire logic linkSoOeN,
  // Shared lines
  input wire logic intLineIn,
  input wire logic intLineOut,
  input wire logic intLineOeN,
  input wire logic wakeLineIn,
  input wire logic wakeLineOut,
  input wire logic wakeLineOeN,
  // Supply, switches, status
  input wire logic logicSupplyOk,
  input wire logic [sdswl_pkg::DUAL_N-1:0] dualPolarityInputs,
  input wire logic [sdswl_pkg::GND_N-1:0] groundOnlyInputs,
  input wire sdswl_pkg::sdswl_cfg_type cfgOut,
  input wire sdswl_pkg::sdswl_mode_type modeOut
);
  // ==========================================================================
  // Checks
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence csFall;
    $fell(linkCsN);
  endsequence
  sequence asleep;
    modeOut == MODE_SLEEP;
  endsequence
  so_enable_a: assert property (csFall |-> ##[1:4] !linkSoOeN)
    else $error("serial output not enabled after select fall");
  so_release_a: assert property ($rose(linkCsN) |-> ##[1:4] linkSoOeN)
    else $error("serial output not released after select rise");
  so_idle_a: assert property (linkCsN [*5] |-> linkSoOeN)
    else $error("serial output driven while deselected");
  int_hold_a: assert property (!intLineOeN && !linkCsN |=> !intLineOeN)
    else $error("interrupt released while selected");
  int_normal_a: assert property ($fell(intLineOeN) |-> modeOut == MODE_NORMAL)
    else $error("interrupt raised outside normal mode");
  int_change_a: assert property (modeOut == MODE_NORMAL
    && |((groundOnlyInputs ^ $past(groundOnlyInputs)) & cfgOut.groundInputEnable)
    |-> ##[1:4] !intLineOeN)
    else $error("enabled switch change gave no interrupt");
  wake_level_a: assert property (wakeLineOeN == (modeOut == MODE_SLEEP)
    && !intLineOut && !wakeLineOut)
    else $error("wake line level does not follow mode");
  wake_fall_a: assert property (asleep ##0 $fell(wakeLineIn) && intLineIn
    |-> ##[1:4] modeOut == MODE_NORMAL)
    else $error("wake line fall did not wake");
  cs_wake_a: assert property (asleep ##0 csFall ##0 logicSupplyOk
    |-> ##[1:4] modeOut == MODE_NORMAL)
    else $error("select fall did not wake");
  cs_nowake_a: assert property (asleep ##0 csFall ##0 !logicSupplyOk
    |=> modeOut == MODE_SLEEP [*4])
    else $error("select fall woke without supply");
  cfg_guard_a: assert property (!$stable(cfgOut) |-> $past(modeOut, 2) == MODE_NORMAL)
    else $error("configuration changed outside normal mode");
endmodule
bind sdswl_top sdswl_properties u_sdswl_properties (.clk(clk), .sys_rst(sys_rst),
  .clkEn(clkEn), .linkSclk(linkSclk), .linkCsN(linkCsN), .linkSi(linkSi),
  .linkSoOut(linkSoOut), .linkSoOeN(linkSoOeN), .intLineIn(intLineIn),
  .intLineOut(intLineOut), .intLineOeN(intLineOeN), .wakeLineIn(wakeLineIn),
  .wakeLineOut(wakeLineOut), .wakeLineOeN(wakeLineOeN), .logicSupplyOk(logicSupplyOk),
  .dualPolarityInputs(dualPolarityInputs), .groundOnlyInputs(groundOnlyInputs),
  .cfgOut(cfgOut), .modeOut(modeOut));
`default_nettype wire

// ==== tb/sdswl_top_tb.sv ====
// Purpose: Self-checking bench of the switch detect serial wake logic
// Assumes: Clock 200 MHz, reset high for 4 cycles
// Notes: Random switch levels from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module sdswl_top_tb;
  import sdswl_pkg::*;
  logic clk, sys_rst, clkEn, csN, sclk, si, soOut, soOeN, intOut, intOeN;
  logic wakeOut, wakeOeN, supplyOk, intPull, wakePull;
  logic [7:0] dualIn, pol, newPol;
  logic [13:0] gndIn;
  sdswl_cfg_type cfg;
  sdswl_mode_type mode;
  wire logic soWire, intIn, wakeIn;
  int seed, err_total, check_count;
  assign soWire = soOeN ? 1'bz : soOut;
  assign intIn = ~((~intOeN & ~intOut) | intPull);
  assign wakeIn = ~((~wakeOeN & ~wakeOut) | wakePull);
  sdswl_top u_sdswl_top (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .linkSclk(sclk),
    .linkCsN(csN), .linkSi(si), .linkSoOut(soOut), .linkSoOeN(soOeN), .intLineIn(intIn),
    .intLineOut(intOut), .intLineOeN(intOeN), .wakeLineIn(wakeIn), .wakeLineOut(wakeOut),
    .wakeLineOeN(wakeOeN), .logicSupplyOk(supplyOk), .dualPolarityInputs(dualIn),
    .groundOnlyInputs(gndIn), .cfgOut(cfg), .modeOut(mode));
  sdswl_host_model u_sdswl_host_model (.linkSclk(sclk), .linkCsN(csN), .linkSi(si),
    .linkSo(soWire));
  // ==========================================================================
  // Helpers
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [23:0] exp_status(logic f, logic [7:0] p, logic [7:0] d,
    logic [13:0] g);
    return {f, 1'b0, ~g, ~(d ^ p)};
  endfunction
  task automatic wait_clk(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_word(string n, logic [23:0] e, logic [23:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %h got %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic chk_cfg(string n, sdswl_cfg_type e, sdswl_cfg_type g);
    check_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %h got %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic frame(logic [23:0] cmd);
    u_sdswl_host_model.xfer(cmd, 24);
    wait_clk(2);
  endtask
  task automatic sleep_now();
    frame({CMD_SLEEP, 16'h0000});
    chk_word("mode", 24'h1, {23'h0, mode});
    chk_word("wake oe", 24'h1, {23'h0, wakeOeN});
  endtask
  task automatic report_and_stop();
    $display("TB: checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_total++;
    report_and_stop();
  end
  // ==========================================================================
  // Scenarios
  initial
  begin
    seed = 98756;
    err_total = 0;
    check_count = 0;
    {clkEn, supplyOk, intPull, wakePull, dualIn, gndIn} = {4'b1100, 8'h00, 14'h3fff};
    #1 sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    wait_clk(8);
    chk_cfg("reset cfg", CFG_RESET, cfg);
    chk_word("reset wake", 24'h0, {23'h0, wakeOeN});
    pol = 8'hff;
    for (int k = 0; k < 6; k++)
    begin
      dualIn = (k == 0) ? 8'hff : 8'($random(seed));
      gndIn = (k == 0) ? 14'h0000 : 14'($random(seed));
      newPol = 8'($random(seed));
      wait_clk(8);
      chk_word("irq set", 24'h0, {23'h0, intOeN});
      frame({CMD_SETTINGS, 8'h00, newPol});
      chk_word("status", exp_status(1'b1, pol, dualIn, gndIn),
        u_sdswl_host_model.rxWord);
      pol = newPol;
      chk_word("pol", {16'h0, pol}, {16'h0, cfg.polarityBattery});
      chk_word("irq clr", 24'h1, {23'h0, intOeN});
    end
    $display("TB: status test done");
    fork
      frame(24'h000000);
      begin
        wait_clk(80);
        gndIn[0] = ~gndIn[0];
      end
    join
    chk_word("irq held", 24'h0, {23'h0, intOeN});
    u_sdswl_host_model.xfer({CMD_SETTINGS, 8'h00, ~pol}, 23);
    wait_clk(2);
    chk_word("short pol", {16'h0, pol}, {16'h0, cfg.polarityBattery});
    chk_word("irq clr2", 24'h1, {23'h0, intOeN});
    frame({CMD_WAKE_GND, 16'h0000});
    frame({CMD_WAKE_DUAL, 16'h0000});
    chk_word("enables", 24'h0, {2'h0, cfg.groundInputEnable, cfg.dualInputEnable});
    gndIn[1] = ~gndIn[1];
    dualIn[0] = ~dualIn[0];
    wait_clk(8);
    chk_word("irq off", 24'h1, {23'h0, intOeN});
    frame({CMD_ANALOG, 16'h0015});
    chk_word("analog", 24'h15, {19'h0, cfg.analogInputSelector});
    frame({CMD_RESET, 16'h0000});
    chk_cfg("cmd reset", CFG_RESET, cfg);
    $display("TB: interrupt test done");
    sleep_now();
    frame({CMD_SETTINGS, 8'h00, 8'h0f});
    chk_word("cs wake", 24'h0, {23'h0, mode});
    chk_word("wake pol", 24'h0f, {16'h0, cfg.polarityBattery});
    sleep_now();
    wakePull = 1'b1;
    wait_clk(6);
    wakePull = 1'b0;
    chk_word("wake pin", 24'h0, {23'h0, mode});
    sleep_now();
    supplyOk = 1'b0;
    wait_clk(6);
    frame({CMD_SETTINGS, 8'h00, 8'h33});
    chk_word("no supply", 24'h1, {23'h0, mode});
    chk_word("sleep pol", 24'h0f, {16'h0, cfg.polarityBattery});
    supplyOk = 1'b1;
    wait_clk(6);
    intPull = 1'b1;
    wait_clk(6);
    intPull = 1'b0;
    chk_word("int wake", 24'h0, {23'h0, mode});
    $display("TB: wake test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
